// ---- hw/sps_pkg.sv ----
`default_nettype none
// ============================================================
// shared constants for the status pin selection logic
package sps_pkg;
	// width of the selection field
	localparam int SPS_SEL_W = 6;
	// selection codes handled by this block
	localparam logic [5:0] SPS_SEL_SYNC_CLK = 6'h0B;
	localparam logic [5:0] SPS_SEL_SYNC_DATA = 6'h0C;
	localparam logic [5:0] SPS_SEL_ASYNC_DATA = 6'h0D;
	localparam logic [5:0] SPS_SEL_CARRIER = 6'h0E;
	localparam logic [5:0] SPS_SEL_CRC_OK = 6'h0F;
	// received signal strength width
	localparam int SPS_RSSI_W = 8;
	// entries in the receive bit buffer
	localparam int SPS_BUF_DEPTH = 2;
	// reset levels
	localparam logic SPS_PIN_RST = 1'b0;
	localparam logic SPS_FLAG_RST = 1'b0;
endpackage
`default_nettype wire

// ---- hw/sps_bit_buffer.sv ----
`default_nettype none
// ============================================================
// small valid/ready buffer holding received bits
module sps_bit_buffer #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// storage words
	logic [WIDTH-1:0] mem_q [DEPTH];
	// write and read pointers
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	// number of stored words
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// pointer wrap shared by both ends
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];

	// storage write, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointer and count upkeep
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wr_ptr_q <= next_ptr(wr_ptr_q);
			if (pop) rd_ptr_q <= next_ptr(rd_ptr_q);
			if (push && !pop) count_q <= count_q + (AW+1)'(1);
			else if (pop && !push) count_q <= count_q - (AW+1)'(1);
		end
	end
endmodule
`default_nettype wire

// ---- hw/sps_status_pin.sv ----
// Contract
// - code 11 drives pin with serial clock
// - receive: data changes on clock falling edge
// - transmit: data sampled on clock rising edge
// - code 12 outputs synchronous received data
// - code 13 outputs received data, no clock
// - crc flag high on match, cleared on restart; a match in the same cycle as a restart wins and sets it
// - code 14 high while strength above threshold
`default_nettype none
// ============================================================
// status pin signal selection
module sps_status_pin
	import sps_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [SPS_SEL_W-1:0] pin_select,
	input wire logic pin_output_invert_flag,
	input wire logic rx_mode,
	input wire logic rx_restart,
	input wire logic link_clk,
	input wire logic host_data,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	output logic rx_bit_ready,
	input wire logic crc_done,
	input wire logic crc_match,
	input wire logic [SPS_RSSI_W-1:0] rssi,
	input wire logic [SPS_RSSI_W-1:0] cs_threshold,
	output logic general_status_pin,
	output logic tx_bit,
	output logic tx_bit_valid
);
	// ============================================================
	// synchronisers
	logic lclk_m_q; // first stage, read only by second
	logic lclk_s_q; // synchronised serial clock
	logic lclk_p_q; // previous synchronised clock
	logic hdat_m_q; // first stage of host data
	logic hdat_s_q; // synchronised host data

	// two flops per outside input
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lclk_m_q <= 1'b0;
			lclk_s_q <= 1'b0;
			hdat_m_q <= 1'b0;
			hdat_s_q <= 1'b0;
		end else begin
			lclk_m_q <= link_clk;
			lclk_s_q <= lclk_m_q;
			hdat_m_q <= host_data;
			hdat_s_q <= hdat_m_q;
		end
	end

	// ============================================================
	// edge detection on the clock as seen at the pin
	// history flop resets to the idle low link level, so neither reset
	// nor a change of the invert flag can fake an edge
	wire raw_rise = lclk_s_q && !lclk_p_q;
	wire raw_fall = !lclk_s_q && lclk_p_q;
	wire pin_fall = pin_output_invert_flag ? raw_rise : raw_fall;
	wire pin_rise = pin_output_invert_flag ? raw_fall : raw_rise;

	// remember last synchronised clock
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lclk_p_q <= 1'b0;
		end else begin
			lclk_p_q <= lclk_s_q;
		end
	end

	// ============================================================
	// receive bit buffer, a stall upstream loses nothing
	logic buf_bit;
	logic buf_valid;
	wire buf_pop = rx_mode && pin_fall;
	sps_bit_buffer #(
		.WIDTH(1),
		.DEPTH(SPS_BUF_DEPTH)
	) u_buf (
		.clk(core_clk),
		.rst_b(rst_b),
		.in_data(rx_bit),
		.in_valid(rx_bit_valid),
		.in_ready(rx_bit_ready),
		.out_data(buf_bit),
		.out_valid(buf_valid),
		.out_ready(buf_pop)
	);

	// ============================================================
	// receive data output register
	logic rx_out_q; // bit presented on the pin
	logic rx_out_d;
	// new bit only on falling edge
	assign rx_out_d = (buf_pop && buf_valid) ? buf_bit : rx_out_q;

	// data register, holds when buffer runs dry
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_out_q <= SPS_PIN_RST;
		end else begin
			rx_out_q <= rx_out_d;
		end
	end

	// ============================================================
	// transmit sampling
	logic tx_bit_q;
	logic tx_valid_q;
	// sample host bit on rising edge
	wire tx_take = !rx_mode && pin_rise;

	// capture host bit, valid for one cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_bit_q <= 1'b0;
			tx_valid_q <= 1'b0;
		end else begin
			tx_valid_q <= tx_take;
			if (tx_take) tx_bit_q <= hdat_s_q;
		end
	end
	assign tx_bit = tx_bit_q;
	assign tx_bit_valid = tx_valid_q;

	// ============================================================
	// checksum and carrier flags
	logic crc_ok_q;
	logic cs_q;
	wire crc_set = crc_done && crc_match;
	wire crc_clr = rx_restart || (crc_done && !crc_match);

	// set beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			crc_ok_q <= SPS_FLAG_RST;
		end else if (crc_set) begin
			crc_ok_q <= 1'b1;
		end else if (crc_clr) begin
			crc_ok_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_q <= SPS_FLAG_RST;
		end else begin
			cs_q <= (rssi > cs_threshold);
		end
	end

	// ============================================================
	// pin selection; unlisted codes give a low level before inversion
	// clock code uses the synchronised link clock
	wire sel_clk = (pin_select == SPS_SEL_SYNC_CLK);
	wire sel_sdat = (pin_select == SPS_SEL_SYNC_DATA);
	// asynchronous data code, same bit without a clock
	wire sel_adat = (pin_select == SPS_SEL_ASYNC_DATA);
	wire sel_cs = (pin_select == SPS_SEL_CARRIER);
	wire sel_crc = (pin_select == SPS_SEL_CRC_OK);
	wire raw_level = (sel_clk & lclk_s_q) | ((sel_sdat | sel_adat) & rx_out_q)
		| (sel_cs & cs_q) | (sel_crc & crc_ok_q);
	logic pin_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q <= SPS_PIN_RST;
		end else begin
			pin_q <= raw_level ^ pin_output_invert_flag;
		end
	end
	assign general_status_pin = pin_q;

	// ============================================================
	// checks
	sequence s_fall_rx;
		rx_mode && pin_fall && buf_valid;
	endsequence
	property p_clk_follow;
		@(posedge core_clk) disable iff (!rst_b)
		sel_clk && $stable(pin_select) |=> pin_q == ($past(lclk_s_q) ^ $past(pin_output_invert_flag));
	endproperty
	a_clk_follow: assert property (p_clk_follow) else $error("pin does not follow serial clock");
	property p_rx_change;
		@(posedge core_clk) disable iff (!rst_b)
		(rx_out_q != $past(rx_out_q)) |-> $past(rx_mode && pin_fall);
	endproperty
	a_rx_change: assert property (p_rx_change) else $error("data changed off falling edge");
	property p_rx_load;
		@(posedge core_clk) disable iff (!rst_b)
		s_fall_rx |=> rx_out_q == $past(buf_bit);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("falling edge missed buffered bit");
	property p_tx_sample;
		@(posedge core_clk) disable iff (!rst_b)
		!rx_mode && pin_rise |=> tx_bit_valid && tx_bit == $past(hdat_s_q);
	endproperty
	a_tx_sample: assert property (p_tx_sample) else $error("host bit not sampled on rise");
	property p_sdat;
		@(posedge core_clk) disable iff (!rst_b)
		sel_sdat && $stable(pin_select) |=> pin_q == ($past(rx_out_q) ^ $past(pin_output_invert_flag));
	endproperty
	a_sdat: assert property (p_sdat) else $error("sync data not on pin");
	property p_adat;
		@(posedge core_clk) disable iff (!rst_b)
		sel_adat && $stable(pin_select) |=> pin_q == ($past(rx_out_q) ^ $past(pin_output_invert_flag));
	endproperty
	a_adat: assert property (p_adat) else $error("async data not on pin");
	property p_crc;
		@(posedge core_clk) disable iff (!rst_b)
		rx_restart && !crc_set |=> !crc_ok_q ##1 (crc_ok_q ? $past(crc_set) : 1'b1);
	endproperty
	a_crc: assert property (p_crc) else $error("crc flag not cleared on restart");
	property p_cs;
		@(posedge core_clk) disable iff (!rst_b)
		sel_cs && (rssi > cs_threshold) && !pin_output_invert_flag ##1 sel_cs && !pin_output_invert_flag |=> pin_q;
	endproperty
	a_cs: assert property (p_cs) else $error("carrier sense pin low above threshold");
	property p_inv;
		@(posedge core_clk) disable iff (!rst_b)
		!(sel_clk | sel_sdat | sel_adat | sel_cs | sel_crc) |=> pin_q == $past(pin_output_invert_flag);
	endproperty
	a_inv: assert property (p_inv) else $error("idle pin level ignores inversion");
endmodule
`default_nettype wire

// ---- tb/sps_host_model.sv ----
`default_nettype none
// ============================================================
// host side: makes the serial clock and presents serial data
module sps_host_model
(
	input wire logic run,
	input wire logic [7:0] pattern,
	output logic link_clk,
	output logic host_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// one frame of eight bits per rise of run, clock still between frames
	initial begin
		link_clk = 1'b0;
		host_data = 1'b0;
		forever begin
			wait (run);
			for (int i = 7; i >= 0; i--) begin
				host_data = pattern[i];
				#32 link_clk = 1'b1;
				#32 link_clk = 1'b0;
			end
			// released line shows the inverse, not a stale level
			host_data = ~host_data;
			wait (!run);
		end
	end
endmodule
`default_nettype wire

// ---- tb/sps_status_pin_tb.sv ----
`default_nettype none
// ============================================================
// self-checking bench for the status pin selection
module sps_status_pin_tb
	import sps_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] sel;
	logic inv, rx_mode, rx_restart, rx_bit, rx_bit_valid, crc_done, crc_match, run;
	logic [7:0] rssi, thr, pattern, got, n;
	wire logic link_clk, host_data, ready, pin, tx_bit, tx_valid;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;
	sps_host_model host (.run(run), .pattern(pattern), .link_clk(link_clk), .host_data(host_data));
	sps_status_pin DUT (.core_clk(core_clk), .rst_b(rst_b), .pin_select(sel), .pin_output_invert_flag(inv),
		.rx_mode(rx_mode), .rx_restart(rx_restart), .link_clk(link_clk), .host_data(host_data), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rx_bit_ready(ready), .crc_done(crc_done), .crc_match(crc_match), .rssi(rssi),
		.cs_threshold(thr), .general_status_pin(pin), .tx_bit(tx_bit), .tx_bit_valid(tx_valid));
	// ============================================================
	// helpers
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	// let the frame finish, then settle
	task automatic frame_end();
		#400 run = 1'b0;
		step(4);
	endtask
	// ============================================================
	// scenarios
	task automatic clock_case(input logic flip);
		step(1);
		sel = SPS_SEL_SYNC_CLK;
		inv = flip;
		run = 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge link_clk);
			#25 check(pin, {7'h00, ~flip});
			@(negedge link_clk);
			#25 check(pin, {7'h00, flip});
		end
		frame_end();
		inv = 1'b0;
	endtask
	task automatic rx_case(input logic [5:0] code);
		step(1);
		sel = code;
		rx_mode = 1'b1;
		rx_bit = 1'b1;
		rx_bit_valid = 1'b1;
		step(1);
		rx_bit = 1'b0;
		step(1);
		rx_bit_valid = 1'b0;
		check(ready, 8'h00);
		run = 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge link_clk);
			// old bit at the first rise, then the stored 1 and 0, then held
			#10 check(pin, (k == 1) ? 8'h01 : 8'h00);
		end
		frame_end();
		check(ready, 8'h01);
	endtask
	task automatic tx_case();
		step(1);
		sel = SPS_SEL_SYNC_CLK;
		rx_mode = 1'b0;
		pattern = 8'hA5;
		run = 1'b1;
		got = 8'h00;
		n = 8'h00;
		// look at the falling edge, where the registered pulse has settled
		repeat (130) @(negedge core_clk) if (tx_valid === 1'b1) begin
			got = {got[6:0], tx_bit};
			n++;
		end
		check(got, 8'hA5);
		check(n, 8'h08);
		frame_end();
	endtask
	task automatic flag_case();
		step(1);
		sel = SPS_SEL_CRC_OK;
		crc_done = 1'b1;
		crc_match = 1'b1;
		step(1);
		crc_done = 1'b0;
		step(3);
		check(pin, 8'h01);
		rx_restart = 1'b1;
		step(1);
		rx_restart = 1'b0;
		step(3);
		check(pin, 8'h00);
		// a match in the same cycle as a restart wins
		crc_done = 1'b1;
		crc_match = 1'b1;
		rx_restart = 1'b1;
		step(1);
		{crc_done, rx_restart} = 2'b00;
		step(3);
		check(pin, 8'h01);
		// a failed comparison clears the flag
		crc_done = 1'b1;
		crc_match = 1'b0;
		step(1);
		crc_done = 1'b0;
		step(3);
		check(pin, 8'h00);
		sel = SPS_SEL_CARRIER;
		rssi = 8'h41;
		thr = 8'h40;
		step(4);
		check(pin, 8'h01);
		rssi = 8'h40;
		step(4);
		check(pin, 8'h00);
		sel = 6'h00;
		inv = 1'b1;
		step(3);
		check(pin, 8'h01);
		inv = 1'b0;
	endtask
	// ============================================================
	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		{sel, inv, rx_mode, rx_restart, rx_bit, rx_bit_valid, crc_done, crc_match, run} = '0;
		{rssi, thr, pattern} = '0;
		step(5);
		rst_b = 1'b1;
		step(2);
		clock_case(1'b0);
		clock_case(1'b1);
		rx_case(SPS_SEL_SYNC_DATA);
		rx_case(SPS_SEL_ASYNC_DATA);
		tx_case();
		flag_case();
		print_verdict();
	end
endmodule
`default_nettype wire
